/* logic/ppr_crossbar.sv */
`timescale 1ns/1ps
module ppr_crossbar
#(
  parameter int PIN_COUNT = ppr_pkg::NUM_PINS
)
(
  input wire logic clk,
  input wire logic srst,
  input wire ppr_pkg::ppr_route_wr_t routeWr,
  input wire ppr_pkg::ppr_key_wr_t keyWr,
  input wire logic lockWrite,
  input wire logic lockValue,
  input wire logic [ppr_pkg::NUM_PINS-1:0] pinIn,
  input wire logic [ppr_pkg::NUM_PINS-1:0] pinAnalogEn,
  input wire logic [ppr_pkg::NUM_PINS-1:0] pinDirInput,
  input wire logic [ppr_pkg::NUM_PINS-1:0] portOut,
  input wire logic [ppr_pkg::NUM_PINS-1:0] pmpOutEn,
  input wire logic [ppr_pkg::NUM_PINS-1:0] pmpOut,
  input wire logic [ppr_pkg::NUM_PINS-1:0] specialOutEn,
  input wire logic [ppr_pkg::NUM_PINS-1:0] specialOut,
  input wire logic [ppr_pkg::NUM_FUNCS-1:0] periphOut,
  input wire logic [ppr_pkg::NUM_INPUTS-1:0] periphInIdle,
  output logic [ppr_pkg::NUM_PINS-1:0] pinOut_ff,
  output logic [ppr_pkg::NUM_PINS-1:0] pinOe_ff,
  output logic [ppr_pkg::NUM_INPUTS-1:0] periphIn_ff,
  output logic lock_ff
);
  // ----------------------------------------------------------------
  // Route tables
  // ----------------------------------------------------------------
  logic [4:0] inSel_ff [ppr_pkg::NUM_INPUTS];
  logic [4:0] outSel_ff [ppr_pkg::NUM_PINS];
  wire logic wrOk = routeWr.valid && !lock_ff;
  wire logic wrIn = wrOk && !routeWr.isOutput && routeWr.index < 5'(ppr_pkg::NUM_INPUTS);
  wire logic wrOut = wrOk && routeWr.isOutput && routeWr.index < 5'(PIN_COUNT);

  ppr_lock_ctl lockCtl
  (
    .clk(clk),
    .srst(srst),
    .keyWr(keyWr),
    .lockWrite(lockWrite),
    .lockValue(lockValue),
    .lock_ff(lock_ff)
  );

  // Selectors store any code; legality is judged where they are used.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < ppr_pkg::NUM_INPUTS; i++)
    begin
      if (srst)
        inSel_ff[i] <= ppr_pkg::SEL_RESET;
      else if (wrIn && routeWr.index == 5'(i))
        inSel_ff[i] <= routeWr.value;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int p = 0; p < ppr_pkg::NUM_PINS; p++)
    begin
      if (srst)
        outSel_ff[p] <= ppr_pkg::FUNC_NULL;
      else if (wrOut && routeWr.index == 5'(p))
        outSel_ff[p] <= routeWr.value;
    end
  end

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // A pin is usable by the crossbar only inside the variant's count.
  function automatic logic pinExists(input logic [4:0] sel);
    pinExists = sel < 5'(PIN_COUNT);
  endfunction

  logic [ppr_pkg::NUM_PINS-1:0] remapOutEn;
  logic [ppr_pkg::NUM_PINS-1:0] remapOut;
  logic [ppr_pkg::NUM_PINS-1:0] nxt_pinOut;
  logic [ppr_pkg::NUM_PINS-1:0] nxt_pinOe;
  logic [ppr_pkg::NUM_INPUTS-1:0] nxt_periphIn;

  always_comb
  begin
    for (int p = 0; p < ppr_pkg::NUM_PINS; p++)
    begin
      remapOutEn[p] = pinExists(5'(p)) && outSel_ff[p] != ppr_pkg::FUNC_NULL;
      remapOut[p] = periphOut[outSel_ff[p]] && remapOutEn[p];
      if (specialOutEn[p])
      begin
        nxt_pinOut[p] = specialOut[p];
        nxt_pinOe[p] = 1'b1;
      end
      else if (remapOutEn[p])
      begin
        nxt_pinOut[p] = remapOut[p];
        nxt_pinOe[p] = 1'b1;
      end
      else if (pmpOutEn[p])
      begin
        nxt_pinOut[p] = pmpOut[p];
        nxt_pinOe[p] = 1'b1;
      end
      else
      begin
        // Remapped inputs play no part here.
        nxt_pinOut[p] = portOut[p];
        nxt_pinOe[p] = !pinDirInput[p];
      end
    end
    for (int i = 0; i < ppr_pkg::NUM_INPUTS; i++)
    begin
      if (pinExists(inSel_ff[i]) && !pinAnalogEn[inSel_ff[i]])
        nxt_periphIn[i] = pinIn[inSel_ff[i]];
      else
        nxt_periphIn[i] = periphInIdle[i];
    end
  end

  // The output stage adds one cycle of latency so every output is a flop.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinOut_ff <= '0;
      pinOe_ff <= '0;
      periphIn_ff <= '0;
    end
    else
    begin
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
      periphIn_ff <= nxt_periphIn;
    end
  end
endmodule

/* logic/ppr_lock_ctl.sv */
`timescale 1ns/1ps
module ppr_lock_ctl
(
  input wire logic clk,
  input wire logic srst,
  input wire ppr_pkg::ppr_key_wr_t keyWr,
  input wire logic lockWrite,
  input wire logic lockValue,
  output logic lock_ff
);
  ppr_pkg::ppr_key_t key_ff;
  ppr_pkg::ppr_key_t nxt_key;
  logic nxt_lock;

  // Any other byte written to the low control byte breaks the sequence.
  always_comb
  begin
    nxt_key = key_ff;
    nxt_lock = lock_ff;
    case (key_ff)
      ppr_pkg::KEY_IDLE:
        if (keyWr.valid && keyWr.data == ppr_pkg::UNLOCK_KEY1)
          nxt_key = ppr_pkg::KEY_GOT1;
      ppr_pkg::KEY_GOT1:
        if (keyWr.valid)
          nxt_key = (keyWr.data == ppr_pkg::UNLOCK_KEY2) ? ppr_pkg::KEY_OPEN : ppr_pkg::KEY_IDLE;
      ppr_pkg::KEY_OPEN:
        if (lockWrite)
        begin
          nxt_lock = lockValue;
          nxt_key = ppr_pkg::KEY_IDLE;
        end
        else if (keyWr.valid)
          nxt_key = (keyWr.data == ppr_pkg::UNLOCK_KEY1) ? ppr_pkg::KEY_GOT1 : ppr_pkg::KEY_IDLE;
      default:
        nxt_key = ppr_pkg::KEY_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      key_ff <= ppr_pkg::KEY_IDLE;
      lock_ff <= ppr_pkg::LOCK_RESET;
    end
    else
    begin
      key_ff <= nxt_key;
      lock_ff <= nxt_lock;
    end
  end
endmodule

/* logic/ppr_pkg.sv */
// Notes on behaviour
// - Only the remappable pin set carries remapped peripheral signals.
// - Inputs and outputs are routed independently, each to any remappable pin.
// - Up to 26 remappable pins; variant count set by a parameter.
// - Software remaps at run time; the lock blocks accidental changes.
// - Routable: UART, SPI, timer clocks, capture, compare, interrupts, comparators.
// - I2C, change notify, calendar alarm and analog peripherals stay fixed.
// - A routable peripheral reaches no pin until one is assigned.
// - Fixed peripherals always use their own pin when active.
// - A remapped output beats port output and parallel master port.
// - Specialized fixed outputs beat a remapped output on the same pin.
// - A remapped input never drives the pin's output buffer.
// - Input pin buffer follows direction bit or a fixed peripheral only.
// - In digital mode the remapped input sees the sampled pin level.
// - An analog function on a pin disables remapped inputs from it.
// - Each routable input has a 5-bit selector naming its source pin.
// - Each pin has a 5-bit output function selector; zero is unconnected.
// - Reset puts the null function on every pin output selector.
// - While locked, route writes are ignored; lock changes need 46h then 57h.
package ppr_pkg;
  localparam int NUM_PINS = 26;
  localparam int NUM_INPUTS = 23;
  localparam int NUM_FUNCS = 32;
  localparam int SEL_W = 5;
  localparam logic [4:0] FUNC_NULL = 5'h00;
  localparam logic [4:0] SEL_RESET = 5'h1F;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
  localparam logic LOCK_RESET = 1'b0;

  typedef enum {KEY_IDLE, KEY_GOT1, KEY_OPEN} ppr_key_t;

  // Route write request: kind chooses input or output table.
  typedef struct packed {
    logic valid;
    logic isOutput;
    logic [4:0] index;
    logic [4:0] value;
  } ppr_route_wr_t;

  // Lock-control write: byte to the oscillator control low byte.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ppr_key_wr_t;
endpackage

/* verification/peripheral_pin_remap_bench.sv */
`timescale 1ns/1ps
module peripheral_pin_remap_bench;
  logic clk = 1'b0;
  logic srst = 1'b1, lockWrite = 1'b0, lockValue = 1'b0, lock_ff;
  ppr_pkg::ppr_route_wr_t routeWr = '0;
  ppr_pkg::ppr_key_wr_t keyWr = '0;
  logic [25:0] pinIn = '0, pinAnalogEn = '0, pmpOutEn = 26'h8, specialOutEn = '0, pinOut_ff, pinOe_ff;
  logic [25:0] pinDirInput = '1, portOut = '0, pmpOut = '1, specialOut = '1;
  logic [31:0] periphOut;
  logic [22:0] periphInIdle, periphIn_ff;
  int n_fail = 0;
  int n_checks = 0;
  initial forever #20 clk = ~clk;
  ppr_periph_model u_peer
  (
    .periphOut(periphOut),
    .periphInIdle(periphInIdle)
  );
  ppr_crossbar DUT
  (
    .clk(clk),
    .srst(srst),
    .routeWr(routeWr),
    .keyWr(keyWr),
    .lockWrite(lockWrite),
    .lockValue(lockValue),
    .pinIn(pinIn),
    .pinAnalogEn(pinAnalogEn),
    .pinDirInput(pinDirInput),
    .portOut(portOut),
    .pmpOutEn(pmpOutEn),
    .pmpOut(pmpOut),
    .specialOutEn(specialOutEn),
    .specialOut(specialOut),
    .periphOut(periphOut),
    .periphInIdle(periphInIdle),
    .pinOut_ff(pinOut_ff),
    .pinOe_ff(pinOe_ff),
    .periphIn_ff(periphIn_ff),
    .lock_ff(lock_ff)
  );
  task chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task wr(input logic o, logic [4:0] i, v);
    routeWr <= '{1'b1, o, i, v};
    @(negedge clk);
    routeWr <= '0;
    repeat (2) @(negedge clk);
  endtask
  task lk(input logic v, logic [7:0] second);
    keyWr <= '{1'b1, ppr_pkg::UNLOCK_KEY1};
    @(negedge clk);
    keyWr <= '{1'b1, second};
    @(negedge clk);
    keyWr <= '0;
    lockValue <= v;
    lockWrite <= 1'b1;
    @(negedge clk);
    lockWrite <= 1'b0;
  endtask
  task close_out;
    $display("%0d checks, %0d mismatches", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(pinOe_ff, 26'h8);
    chk(pinOut_ff, 26'h8);
    chk(lock_ff, 1'b0);
    chk(periphIn_ff, periphInIdle);
    $display("reset test done");
    wr(1'b1, 5'h03, 5'h07);
    chk(pinOut_ff[3], periphOut[7]);
    specialOutEn <= 26'h8;
    wr(1'b0, 5'h00, 5'h05);
    chk(pinOut_ff[3], 1'b1);
    pinIn <= 26'h20;
    wr(1'b1, 5'h03, 5'h00);
    chk(periphIn_ff[0], 1'b1);
    chk(pinOe_ff[5], 1'b0);
    pinAnalogEn <= '1;
    wr(1'b1, 5'h04, 5'h16);
    chk(periphIn_ff, periphInIdle);
    $display("route test done");
    lk(1'b1, ppr_pkg::UNLOCK_KEY2);
    chk(lock_ff, 1'b1);
    wr(1'b1, 5'h04, 5'h00);
    chk(pinOut_ff[4], periphOut[22]);
    lk(1'b0, ppr_pkg::UNLOCK_KEY2);
    chk(lock_ff, 1'b0);
    wr(1'b1, 5'h04, 5'h00);
    chk(pinOe_ff[4], 1'b0);
    lk(1'b1, 8'h12);
    chk(lock_ff, 1'b0);
    $display("lock test done");
    pinDirInput <= 26'h3FF_FFBF;
    portOut <= 26'h40;
    repeat (2) @(negedge clk);
    chk(pinOe_ff[6], 1'b1);
    chk(pinOut_ff[6], 1'b1);
    wr(1'b1, 5'h06, 5'h01);
    chk(pinOut_ff[6], periphOut[1]);
    $display("port test done");
    pinAnalogEn <= '0;
    wr(1'b0, 5'h02, 5'h05);
    chk(periphIn_ff[2], pinIn[5]);
    wr(1'b0, 5'h02, 5'h1A);
    chk(periphIn_ff[2], periphInIdle[2]);
    $display("range test done");
    lk(1'b1, ppr_pkg::UNLOCK_KEY2);
    srst <= 1'b1;
    repeat (3) @(negedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(pinOut_ff, 26'h48);
    chk(pinOe_ff, 26'h48);
    chk(periphIn_ff, periphInIdle);
    chk(lock_ff, 1'b0);
    $display("second reset test done");
    close_out;
  end
endmodule

/* verification/ppr_crossbar_monitor.sv */
`timescale 1ns/1ps
module ppr_crossbar_monitor
(
  input wire logic clk,
  input wire logic srst,
  input wire ppr_pkg::ppr_route_wr_t routeWr,
  input wire logic lockWrite,
  input wire logic lockValue,
  input wire logic [25:0] pinIn,
  input wire logic [25:0] pinAnalogEn,
  input wire logic [25:0] pinDirInput,
  input wire logic [25:0] pmpOutEn,
  input wire logic [25:0] specialOutEn,
  input wire logic [25:0] specialOut,
  input wire logic [25:0] pinOut_ff,
  input wire logic [25:0] pinOe_ff,
  input wire logic [22:0] periphInIdle,
  input wire logic [22:0] periphIn_ff,
  input wire logic lock_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // A fixed driver is a floor for the enable, whatever the crossbar holds.
  wire logic [25:0] fixDrv = ~pinDirInput | pmpOutEn | specialOutEn;
  wire logic [74:0] inSrc = {pinIn, pinAnalogEn, periphInIdle};
  property p_rst; $fell(srst) |-> !pinOe_ff && !periphIn_ff && !lock_ff; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_lck; $changed(lock_ff) |-> $past(lockWrite) && lock_ff == $past(lockValue); endproperty
  a_lck: assert property (p_lck) else $error("lock moved");
  property p_soe; 1 |=> (pinOe_ff & $past(specialOutEn)) == $past(specialOutEn); endproperty
  a_soe: assert property (p_soe) else $error("special enable");
  property p_sot; 1 |=> ((pinOut_ff ^ $past(specialOut)) & $past(specialOutEn)) == '0; endproperty
  a_sot: assert property (p_sot) else $error("special level");
  property p_fix; 1 |=> (~pinOe_ff & $past(fixDrv)) == '0; endproperty
  a_fix: assert property (p_fix) else $error("fixed driver");
  property p_ana; &pinAnalogEn |=> periphIn_ff == $past(periphInIdle); endproperty
  a_ana: assert property (p_ana) else $error("analog input");
  property p_oes; !$past(srst) && !$past(routeWr.valid) && $stable(fixDrv) |=> $stable(pinOe_ff); endproperty
  a_oes: assert property (p_oes) else $error("enable moved");
  property p_ins; !$past(srst) && !$past(routeWr.valid) && $stable(inSrc) |=> $stable(periphIn_ff); endproperty
  a_ins: assert property (p_ins) else $error("input moved");
endmodule
bind ppr_crossbar ppr_crossbar_monitor u_mon
(
  .clk(clk),
  .srst(srst),
  .routeWr(routeWr),
  .lockWrite(lockWrite),
  .lockValue(lockValue),
  .pinIn(pinIn),
  .pinAnalogEn(pinAnalogEn),
  .pinDirInput(pinDirInput),
  .pmpOutEn(pmpOutEn),
  .specialOutEn(specialOutEn),
  .specialOut(specialOut),
  .pinOut_ff(pinOut_ff),
  .pinOe_ff(pinOe_ff),
  .periphInIdle(periphInIdle),
  .periphIn_ff(periphIn_ff),
  .lock_ff(lock_ff)
);

/* verification/ppr_periph_model.sv */
`timescale 1ns/1ps
module ppr_periph_model
(
  output logic [31:0] periphOut,
  output logic [22:0] periphInIdle
);
  // Code zero is the null function, so bit 0 never drives.
  assign periphOut = 32'hA5C3_5A3C;
  assign periphInIdle = 23'h2A_AAAA;
endmodule
